// ===== logic/pllcs_ctrl.sv
// Oscillator calibration trigger, counter sync mode and path delay control
//
// The plain strobed port was decided locally.
`default_nettype none
`include "pllcs_params.svh"
module pllcs_ctrl
    import pllcs_pkg::*;
#(
    parameter int CAL_TICKS = `PLLCS_CAL_TICKS
) (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    input  wire logic [9:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       sync_pin_b,
    output logic            cnt_rst_async,
    output logic            cnt_rst_sync,
    output logic      [2:0] ref_path_dly,
    output logic      [2:0] fb_path_dly,
    output logic            cal_busy,
    output logic            cal_valid,
    output logic      [1:0] cal_div_sel
);
    // ------------------------------------------------------------
    // Buffered and active registers
    // ------------------------------------------------------------
    logic [7:0]       sync_buf_q;
    logic [7:0]       sync_act_q;
    logic [7:0]       cal_buf_q;
    logic [7:0]       cal_act_q;
    logic             cal_bit_prev_q;
    logic             update;
    pllcs_cal_state_t state_q;
    logic [15:0]      tick_cnt_q;
    logic             tick;
    logic             sync_q;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
        hit = (a == off);
    endfunction

    assign update = clk_en && reg_wr && hit(reg_addr, `PLLCS_ADDR_UPDATE) && reg_wdata[`PLLCS_UPD_BIT];

    // Software writes land only in the buffered copies
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_buf_q <= `PLLCS_SYNC_DLY_RST;
            cal_buf_q  <= `PLLCS_CAL_CTRL_RST;
        end else if (clk_en && reg_wr) begin
            if (hit(reg_addr, `PLLCS_ADDR_SYNC_DLY)) begin
                sync_buf_q <= reg_wdata;
            end
            if (hit(reg_addr, `PLLCS_ADDR_CAL_CTRL)) begin
                cal_buf_q <= reg_wdata;
            end
        end
    end

    // Update-all copies every buffered value at once; self clearing
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_act_q <= `PLLCS_SYNC_DLY_RST;
            cal_act_q  <= `PLLCS_CAL_CTRL_RST;
        end else if (update) begin
            sync_act_q <= sync_buf_q;
            cal_act_q  <= cal_buf_q;
        end
    end

    // Read data one cycle after the strobe; calibration status on update addr
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                if (hit(reg_addr, `PLLCS_ADDR_SYNC_DLY)) begin
                    reg_rdata <= sync_buf_q;
                end else if (hit(reg_addr, `PLLCS_ADDR_CAL_CTRL)) begin
                    reg_rdata <= cal_buf_q;
                end else if (hit(reg_addr, `PLLCS_ADDR_UPDATE)) begin
                    reg_rdata <= {5'h00, cal_valid, cal_busy, 1'h0};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------
    assign cal_div_sel = cal_act_q[`PLLCS_CALDIV_HI:`PLLCS_CALDIV_LO];

    pllcs_cal_div u_div (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .run      (state_q == PLLCS_RUN),
        .div_sel  (cal_div_sel),
        .tick     (tick)
    );

    // Previous active bit, for edge detection
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_bit_prev_q <= 1'b0;
        end else if (clk_en) begin
            cal_bit_prev_q <= cal_act_q[`PLLCS_CAL_BIT];
        end
    end

    // Only a rising edge starts a run; a held 1 never restarts it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= PLLCS_IDLE;
            tick_cnt_q <= 16'h0000;
        end else if (clk_en) begin
            if (!cal_act_q[`PLLCS_CAL_BIT]) begin
                state_q    <= PLLCS_IDLE;
                tick_cnt_q <= 16'h0000;
            end else begin
                unique case (state_q)
                    PLLCS_IDLE: begin
                        if (!cal_bit_prev_q) begin
                            state_q    <= PLLCS_RUN;
                            tick_cnt_q <= 16'h0000;
                        end
                    end
                    PLLCS_RUN: begin
                        if (tick) begin
                            if (tick_cnt_q == 16'(CAL_TICKS - 1)) begin
                                state_q <= PLLCS_DONE;
                            end
                            tick_cnt_q <= 16'(tick_cnt_q + 16'h0001);
                        end
                    end
                    PLLCS_DONE: begin
                        state_q <= PLLCS_DONE; // Held until the bit clears
                    end
                    default: begin
                        state_q <= PLLCS_IDLE;
                    end
                endcase
            end
        end
    end

    assign cal_busy  = (state_q == PLLCS_RUN);
    assign cal_valid = (state_q == PLLCS_DONE);

    // ------------------------------------------------------------
    // Counter sync and path delays
    // ------------------------------------------------------------
    // Registered sync pulse for the synchronous mode
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_q <= 1'b0;
        end else if (clk_en) begin
            sync_q <= !sync_pin_b && (sync_act_q[`PLLCS_SYNC_HI:`PLLCS_SYNC_LO] == `PLLCS_SYNC_SYNC);
        end
    end

    // Async mode passes the pin straight through; modes 00 and 11 ignore it
    assign cnt_rst_async = !sync_pin_b
        && (sync_act_q[`PLLCS_SYNC_HI:`PLLCS_SYNC_LO] == `PLLCS_SYNC_ASYNC);
    assign cnt_rst_sync  = sync_q;
    assign ref_path_dly  = sync_act_q[`PLLCS_RDLY_HI:`PLLCS_RDLY_LO];
    assign fb_path_dly   = sync_act_q[`PLLCS_NDLY_HI:`PLLCS_NDLY_LO];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_cal_rise;
        !cal_bit_prev_q && cal_act_q[`PLLCS_CAL_BIT] && state_q == PLLCS_IDLE && clk_en;
    endsequence

    AST_CAL_START: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_cal_rise |=> cal_busy)
        else $error("calibration did not start on rising bit");
    AST_NO_RESTART: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cal_valid && cal_act_q[`PLLCS_CAL_BIT]) |=> !cal_busy)
        else $error("held bit restarted calibration");
    AST_DISCARD: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && !cal_act_q[`PLLCS_CAL_BIT]) |=> !cal_valid && !cal_busy)
        else $error("calibration result kept after clear");
    AST_BUF_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
        !update |=> $stable(sync_act_q) && $stable(cal_act_q))
        else $error("active set changed without update");
    AST_COPY: assert property (@(posedge core_clk) disable iff (!rst_b)
        update |=> sync_act_q == $past(sync_buf_q) && cal_act_q == $past(cal_buf_q))
        else $error("update did not copy buffered values");
    AST_ASYNC: assert property (@(posedge core_clk) disable iff (!rst_b)
        cnt_rst_async |-> sync_act_q[`PLLCS_SYNC_HI:`PLLCS_SYNC_LO] == `PLLCS_SYNC_ASYNC && !sync_pin_b)
        else $error("async reset in wrong mode");
    AST_SYNC: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && !sync_pin_b && sync_act_q[`PLLCS_SYNC_HI:`PLLCS_SYNC_LO] == `PLLCS_SYNC_SYNC) |=> cnt_rst_sync)
        else $error("sync reset missing");
    AST_IGNORE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sync_act_q[`PLLCS_SYNC_HI:`PLLCS_SYNC_LO] == `PLLCS_SYNC_NONE
            || sync_act_q[`PLLCS_SYNC_HI:`PLLCS_SYNC_LO] == 2'h3) |-> !cnt_rst_async)
        else $error("sync pin acted in idle mode");
    AST_SYNC_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && sync_act_q[`PLLCS_SYNC_HI:`PLLCS_SYNC_LO] != `PLLCS_SYNC_SYNC) |=> !cnt_rst_sync)
        else $error("sync reset outside synchronous mode");
    AST_VALID_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && cal_valid && cal_act_q[`PLLCS_CAL_BIT]) |=> cal_valid)
        else $error("calibration result lost while bit held");
    AST_DLY: assert property (@(posedge core_clk) disable iff (!rst_b)
        update |=> ref_path_dly == $past(sync_buf_q[`PLLCS_RDLY_HI:`PLLCS_RDLY_LO])
            && fb_path_dly == $past(sync_buf_q[`PLLCS_NDLY_HI:`PLLCS_NDLY_LO]))
        else $error("path delay mismatch");
endmodule
`default_nettype wire

// ===== logic/pllcs_params.svh
// Constants for the oscillator calibration and counter sync control block
`ifndef PLLCS_PARAMS_SVH
`define PLLCS_PARAMS_SVH

// Register offsets (10-bit register address space)
`define PLLCS_ADDR_SYNC_DLY   10'h019
`define PLLCS_ADDR_CAL_CTRL   10'h018
`define PLLCS_ADDR_UPDATE     10'h232

// Field positions in the sync and path delay register
`define PLLCS_SYNC_HI         7
`define PLLCS_SYNC_LO         6
`define PLLCS_RDLY_HI         5
`define PLLCS_RDLY_LO         3
`define PLLCS_NDLY_HI         2
`define PLLCS_NDLY_LO         0

// Field positions in the calibration control and update registers
`define PLLCS_CALDIV_HI       2
`define PLLCS_CALDIV_LO       1
`define PLLCS_CAL_BIT         0
`define PLLCS_UPD_BIT         0

// Reset values
`define PLLCS_SYNC_DLY_RST    8'h00
`define PLLCS_CAL_CTRL_RST    8'h06

// Sync pin modes
`define PLLCS_SYNC_NONE       2'h0
`define PLLCS_SYNC_ASYNC      2'h1
`define PLLCS_SYNC_SYNC       2'h2

// Calibration run length in calibration clock ticks
`define PLLCS_CAL_TICKS       16'h0100

`endif

// ===== logic/pllcs_pkg.sv
// Types for the oscillator calibration and counter sync control block
`default_nettype none
package pllcs_pkg;
    typedef enum logic [1:0] {
        PLLCS_IDLE = 2'h0,
        PLLCS_RUN  = 2'h1,
        PLLCS_DONE = 2'h3
    } pllcs_cal_state_t;
endpackage
`default_nettype wire

// ===== logic/pllcs_cal_div.sv
// Calibration clock divider: makes a tick every 2, 4, 8 or 16 reference cycles
`default_nettype none
`include "pllcs_params.svh"
module pllcs_cal_div
    import pllcs_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    input  wire logic       run,
    input  wire logic [1:0] div_sel,
    output logic            tick
);
    logic [3:0] cnt_q;
    logic [3:0] last;

    // Terminal count per code; code 3 divides by 16
    always_comb begin
        last = 4'((4'h2 << div_sel) - 4'h1);
    end

    // Counter restarts whenever calibration is not running
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
        end else if (clk_en) begin
            if (!run || cnt_q == last) begin
                cnt_q <= 4'h0;
            end else begin
                cnt_q <= 4'(cnt_q + 4'h1);
            end
        end
    end

    assign tick = run && clk_en && (cnt_q == last);

    AST_DIV16: assert property (@(posedge core_clk) disable iff (!rst_b)
        (run && clk_en && div_sel == 2'h3 && cnt_q == 4'h0) |-> !tick)
        else $error("divide by 16 ticked early");
endmodule
`default_nettype wire

// ===== bench/pllcs_sync_drv.sv
// Sync pin source model standing in for the board driver
`default_nettype none
module pllcs_sync_drv (
    input  wire logic core_clk,
    output var logic  sync_pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin idles high; it is a driven level, never left floating
    initial sync_pin_b = 1'b1;
    // Level changes land just after a rising edge
    task automatic drive(input logic lvl);
        @(posedge core_clk);
        sync_pin_b <= lvl;
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the calibration and counter sync control block
`default_nettype none
`include "pllcs_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pllcs_pkg::*;
    localparam logic [9:0] A_SYNC = `PLLCS_ADDR_SYNC_DLY;
    localparam logic [9:0] A_CAL  = `PLLCS_ADDR_CAL_CTRL;
    localparam logic [9:0] A_UPD  = `PLLCS_ADDR_UPDATE;
    localparam int         CAL_T  = 4;
    logic       core_clk  = 1'b0;
    logic       clk_en    = 1'b1;
    logic       rst_b     = 1'b0;
    logic [9:0] reg_addr  = 10'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata;
    logic       sync_pin_b;
    logic       cnt_rst_async;
    logic       cnt_rst_sync;
    logic [2:0] ref_path_dly;
    logic [2:0] fb_path_dly;
    logic       cal_busy;
    logic       cal_valid;
    logic [1:0] cal_div_sel;
    int         n_mismatch = 0;
    int         tests_run  = 0;
    // Short calibration keeps the run brief; expectations scale with it
    pllcs_ctrl #(.CAL_TICKS(CAL_T)) u_dut (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_pin_b(sync_pin_b),
        .cnt_rst_async(cnt_rst_async), .cnt_rst_sync(cnt_rst_sync),
        .ref_path_dly(ref_path_dly), .fb_path_dly(fb_path_dly),
        .cal_busy(cal_busy), .cal_valid(cal_valid), .cal_div_sel(cal_div_sel)
    );
    pllcs_sync_drv u_sync (.core_clk(core_clk), .sync_pin_b(sync_pin_b));
    always #5 core_clk = ~core_clk;
    // ----------------------------------------
    // Bus cycles and comparison
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Copy takes an edge, calibration busy follows one edge later
    task automatic upd();
        wr(A_UPD, 8'h01);
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic run_cal(input logic [1:0] code, output int cyc);
        wr(A_CAL, {5'h00, code, 1'b0});
        upd();
        wr(A_CAL, {5'h00, code, 1'b1});
        upd();
        check(8'(cal_busy), 8'h01);
        cyc = 0;
        while (cal_valid !== 1'b1 && cyc < 400) begin
            @(posedge core_clk);
            #1;
            cyc++;
        end
        check(8'(cal_valid), 8'h01);
        check(8'(cal_div_sel), 8'(code));
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] d;
        wr(10'h3FF, 8'hFF);
        rd(A_SYNC, d);
        check(d, 8'h00);
        rd(A_CAL, d);
        check(d, 8'h06);
        rd(10'h3FF, d);
        check(d, 8'h00);
        check(8'(cal_div_sel), 8'h03);
        $display("reset values done");
    endtask
    task automatic t_buffer();
        logic [7:0] d;
        wr(A_SYNC, 8'h2B);
        rd(A_SYNC, d);
        check(d, 8'h2B);
        check({2'h0, ref_path_dly, fb_path_dly}, 8'h00);
        upd();
        check({2'h0, ref_path_dly, fb_path_dly}, 8'h2B);
        $display("buffered delays done");
    endtask
    // With the enable low, neither a write nor an update may land
    task automatic t_freeze();
        logic [7:0] d;
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(A_SYNC, 8'h11);
        upd();
        check({2'h0, ref_path_dly, fb_path_dly}, 8'h2B);
        @(posedge core_clk);
        clk_en <= 1'b1;
        rd(A_SYNC, d);
        check(d, 8'h2B);
        $display("clock enable freeze done");
    endtask
    task automatic t_sync();
        for (int m = 0; m < 4; m++) begin
            wr(A_SYNC, {m[1:0], 6'h00});
            upd();
            u_sync.drive(1'b0);
            #1;
            check(8'(cnt_rst_async), 8'(m == 1));
            @(posedge core_clk);
            #1;
            check(8'(cnt_rst_sync), 8'(m == 2));
            u_sync.drive(1'b1);
        end
        $display("sync modes done");
    endtask
    task automatic t_cal();
        int n0;
        int n3;
        logic [7:0] d;
        run_cal(2'h0, n0);
        rd(A_UPD, d);
        check(d, 8'h04);
        // Bit held at 1: a further update must not restart
        upd();
        repeat (3) begin
            check(8'({cal_valid, cal_busy}), 8'h02);
            @(posedge core_clk);
            #1;
        end
        wr(A_CAL, 8'h00);
        upd();
        check(8'(cal_valid), 8'h00);
        run_cal(2'h3, n3);
        check(8'(n3 - n0 > 32), 8'h01);
        // Wait loop starts one edge after busy rises, so one cycle short of divider times ticks
        check(8'(n0), 8'(2 * CAL_T - 1));
        check(8'(n3), 8'(16 * CAL_T - 1));
        $display("calibration done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_buffer();
        t_freeze();
        t_sync();
        t_cal();
        tally_and_finish();
    end
    // Whole run is well under a thousand cycles
    initial begin
        #100us;
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
